// ---- rtl/fcd_defines.svh ----
// fcd_defines.svh: constants of the flag-clear and decrement executor
// assumes inclusion by bare name from the executor package and modules
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

// instruction encodings, 16-bit words
`define FCD_OP_CLR_DIV 16'h5080
`define FCD_OP_EN_INT 16'h5060
`define FCD_OP_IRQ_DISABLE_INSTR 16'h5040
`define FCD_OP_CLR_PCHG 16'h4400
`define FCD_OP_CLR_SER 16'h5540
`define FCD_OP_CLR_WDT 16'h17e0
`define FCD_PFX_CLR_EVT 8'h40
`define FCD_PFX_CLR_PARM 12'h16d
`define FCD_PFX_SUB1 9'h095
`define FCD_PFX_SUB1SK 9'h091

// event flag bit positions
`define FCD_EV_DIV 0
`define FCD_EV_T0 1
`define FCD_EV_PORTC 2
`define FCD_EV_RSVD 3
`define FCD_EV_EXT 4
`define FCD_EV_RX 5
`define FCD_EV_TX 6
`define FCD_EV_T1 7
`define FCD_EVT_USED 8'hf7

// parameter flag field: watchdog clock select
`define FCD_PARM_WDT 3
`define FCD_PARM_RST 4'h8

// register byte offsets
`define FCD_OFF_IRQ_STAT 8'h00
`define FCD_OFF_IRQ_MASK 8'h04
`define FCD_OFF_EVT 8'h08
`define FCD_OFF_CORE 8'h0c
`define FCD_OFF_PARM 8'h10
`define FCD_OFF_PSR 8'h14
`define FCD_OFF_DIV 8'h18
`define FCD_OFF_WDT 8'h1c
`define FCD_OFF_MEM_ADDR 8'h20
`define FCD_OFF_MEM_DATA 8'h24

// core register field positions
`define FCD_CORE_CARRY 4
`define FCD_CORE_ZERO 5
`define FCD_CORE_IE 6

// timing: terminal counts of the watchdog prescaler, dividing by 1024 and 16
`define FCD_WDT_SLOW_DIV 10'h3ff
`define FCD_WDT_FAST_DIV 10'h00f

`endif

// ---- rtl/fcd_pkg.sv ----
// fcd_pkg: types of the flag-clear and decrement executor
// assumes fcd_defines.svh is reachable by bare name
`include "fcd_defines.svh"
package fcd_pkg;
   typedef logic [3:0] fcd_nib_t;
   typedef enum logic [3:0] {
      FCD_OP_NONE = 4'h0,
      FCD_OP_CDIV = 4'h1,
      FCD_OP_CEVF = 4'h2,
      FCD_OP_CPMF = 4'h3,
      FCD_OP_CPS0 = 4'h4,
      FCD_OP_CPS2 = 4'h5,
      FCD_OP_CWDT = 4'h6,
      FCD_OP_SUB1 = 4'h7,
      FCD_OP_SUB1SK = 4'h8,
      FCD_OP_DINT = 4'h9,
      FCD_OP_EINT = 4'ha
   } fcd_op_t;
endpackage

// ---- rtl/fcd_flag_bit.sv ----
// fcd_flag_bit: one sticky flag, set by hardware, cleared by a strobe
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ns
module fcd_flag_bit (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // control
   input wire logic setPulse,
   input wire logic clrPulse,
   // state
   output logic flag
);
   // set wins over clear so an event in the clearing cycle is kept
   always_ff @(posedge mclk) begin
      if (reset) begin
         flag <= 1'b0;
      end else begin
         flag <= setPulse | (flag & ~clrPulse);
      end
   end
endmodule

// ---- rtl/fcd_nib_dec.sv ----
// fcd_nib_dec: unsigned four-bit decrement with borrow
// assumes purely combinational use inside the executor
`timescale 1ns/1ns
module fcd_nib_dec import fcd_pkg::*; (
   // operand
   input wire fcd_nib_t value,
   // result
   output fcd_nib_t result,
   output logic borrow
);
   logic [4:0] diff;
   // zero wraps to fifteen and raises the borrow
   always_comb begin
      diff = {1'b0, value} - 5'h01;
      result = diff[3:0];
      borrow = diff[4];
   end
endmodule

// ---- rtl/fcd_top.sv ----
// fcd_top: executes flag-clear, decrement and interrupt-disable instructions
// assumes instructions and peripheral events arrive on mclk, one per cycle
`timescale 1ns/1ns
`include "fcd_defines.svh"

module fcd_top import fcd_pkg::*; (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // instruction from the decode core
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   // peripheral event pulses
   input wire logic timer0Underflow,
   input wire logic portCChange,
   input wire logic extIrqFall,
   input wire logic serialRxDone,
   input wire logic serialTxDone,
   input wire logic timer1Underflow,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // execution results
   output logic instrDone,
   output logic [1:0] pcAdvance,
   output fcd_nib_t accumulator,
   output logic carryFlag,
   output logic zeroFlag,
   output logic intEnable,
   output logic wdtExpired,
   output logic irq
);
   fcd_op_t op;
   fcd_nib_t memory [0:127];
   fcd_nib_t memOperand;
   fcd_nib_t decResult;
   fcd_nib_t parameterFlags;
   logic decBorrow;
   logic [6:0] opAddr;
   logic [7:0] imm;
   logic [13:0] prescaleDivider;
   logic [9:0] wdtPrescale;
   logic [17:0] watchdog;
   logic wdtTick;
   logic divOverflow;
   logic isDec;
   logic [7:0] eventPulse;
   logic [7:0] eventClear;
   logic [7:0] eventFlags;
   logic [7:0] irqStatus;
   logic [7:0] irqMask;
   logic statusRead;
   logic portCChangeStatus;
   logic [1:0] serialStatusFlags;
   logic [6:0] memAddrReg;
   logic [31:0] next_rdData;

   // decode of the instruction word into one operation class
   always_comb begin
      op = FCD_OP_NONE;
      if (instrValid) begin
         if (instrWord == `FCD_OP_CLR_DIV) begin
            op = FCD_OP_CDIV;
         end else if (instrWord == `FCD_OP_EN_INT) begin
            op = FCD_OP_EINT;
         end else if (instrWord == `FCD_OP_IRQ_DISABLE_INSTR) begin
            op = FCD_OP_DINT;
         end else if (instrWord == `FCD_OP_CLR_PCHG) begin
            op = FCD_OP_CPS0;
         end else if (instrWord == `FCD_OP_CLR_SER) begin
            op = FCD_OP_CPS2;
         end else if (instrWord == `FCD_OP_CLR_WDT) begin
            op = FCD_OP_CWDT;
         end else if (instrWord[15:8] == `FCD_PFX_CLR_EVT) begin
            op = FCD_OP_CEVF;
         end else if (instrWord[15:4] == `FCD_PFX_CLR_PARM) begin
            op = FCD_OP_CPMF;
         end else if (instrWord[15:7] == `FCD_PFX_SUB1) begin
            op = FCD_OP_SUB1;
         end else if (instrWord[15:7] == `FCD_PFX_SUB1SK) begin
            op = FCD_OP_SUB1SK;
         end
      end
   end

   // operand fields: direct address in the low seven bits
   assign opAddr = instrWord[6:0];
   assign imm = instrWord[7:0];
   assign memOperand = memory[opAddr];
   assign isDec = (op == FCD_OP_SUB1) || (op == FCD_OP_SUB1SK);

   fcd_nib_dec u_dec (
      .value(memOperand),
      .result(decResult),
      .borrow(decBorrow)
   );

   // data memory: an executing decrement outranks a software write
   always_ff @(posedge mclk) begin
      if (isDec) begin
         memory[opAddr] <= decResult;
      end else if (regWrite && regAddr == `FCD_OFF_MEM_DATA) begin
         memory[memAddrReg] <= regWrData[3:0];
      end
   end

   // accumulator and flags; carry means no borrow occurred
   always_ff @(posedge mclk) begin
      if (reset) begin
         accumulator <= 4'h0;
         carryFlag <= 1'b0;
         zeroFlag <= 1'b0;
      end else if (isDec) begin
         accumulator <= decResult;
         carryFlag <= ~decBorrow;
         zeroFlag <= (decResult == 4'h0);
      end
   end

   // program counter step, skip on a nonzero four-bit result
   always_ff @(posedge mclk) begin
      if (reset) begin
         instrDone <= 1'b0;
         pcAdvance <= 2'h0;
      end else begin
         instrDone <= (op != FCD_OP_NONE);
         if (op == FCD_OP_SUB1SK && decResult != 4'h0) begin
            pcAdvance <= 2'h2;
         end else if (op != FCD_OP_NONE) begin
            pcAdvance <= 2'h1;
         end else begin
            pcAdvance <= 2'h0;
         end
      end
   end

   // interrupt enable; reset leaves interrupts blocked until enabled
   always_ff @(posedge mclk) begin
      if (reset) begin
         intEnable <= 1'b0;
      end else if (op == FCD_OP_DINT) begin
         intEnable <= 1'b0;
      end else if (op == FCD_OP_EINT) begin
         intEnable <= 1'b1;
      end
   end

   // prescale divider: free running, overflow raises an event
   assign divOverflow = (prescaleDivider == 14'h3fff);
   always_ff @(posedge mclk) begin
      if (reset) begin
         prescaleDivider <= 14'h0000;
      end else if (op == FCD_OP_CDIV) begin
         prescaleDivider <= {prescaleDivider[13:4], 4'h0};
      end else begin
         prescaleDivider <= prescaleDivider + 14'h0001;
      end
   end

   // parameter flags: a clear bit 3 picks the slow watchdog clock
   always_ff @(posedge mclk) begin
      if (reset) begin
         parameterFlags <= `FCD_PARM_RST;
      end else if (op == FCD_OP_CPMF) begin
         parameterFlags[`FCD_PARM_WDT] <=
            parameterFlags[`FCD_PARM_WDT] & ~imm[3];
      end else if (regWrite && regAddr == `FCD_OFF_PARM) begin
         parameterFlags <= regWrData[3:0];
      end
   end

   // watchdog prescaler: oscillator/1024 or the faster alternative
   always_ff @(posedge mclk) begin
      if (reset) begin
         wdtPrescale <= 10'h000;
      end else if (wdtTick) begin
         wdtPrescale <= 10'h000;
      end else begin
         wdtPrescale <= wdtPrescale + 10'h001;
      end
   end
   assign wdtTick = parameterFlags[`FCD_PARM_WDT] ?
      (wdtPrescale == `FCD_WDT_FAST_DIV) :
      (wdtPrescale == `FCD_WDT_SLOW_DIV);

   // watchdog counter; clearing the low bits only delays expiry
   always_ff @(posedge mclk) begin
      if (reset) begin
         watchdog <= 18'h00000;
         wdtExpired <= 1'b0;
      end else begin
         wdtExpired <= wdtTick && (watchdog == 18'h3ffff);
         if (op == FCD_OP_CWDT) begin
            watchdog <= {watchdog[17:4], 4'h0};
         end else if (wdtTick) begin
            watchdog <= watchdog + 18'h00001;
         end
      end
   end

   // event sources and the instruction's clear mask, bit 3 reserved
   always_comb begin
      eventPulse = 8'h00;
      eventPulse[`FCD_EV_DIV] = divOverflow;
      eventPulse[`FCD_EV_T0] = timer0Underflow;
      eventPulse[`FCD_EV_PORTC] = portCChange;
      eventPulse[`FCD_EV_EXT] = extIrqFall;
      eventPulse[`FCD_EV_RX] = serialRxDone;
      eventPulse[`FCD_EV_TX] = serialTxDone;
      eventPulse[`FCD_EV_T1] = timer1Underflow;
      eventClear = 8'h00;
      if (op == FCD_OP_CEVF) begin
         eventClear = imm & `FCD_EVT_USED;
      end
   end

   assign statusRead = regRead && (regAddr == `FCD_OFF_IRQ_STAT);

   // one event flag and one interrupt status bit per source
   for (genvar i = 0; i < 8; i++) begin : g_evt
      fcd_flag_bit u_evf (
         .mclk(mclk),
         .reset(reset),
         .setPulse(eventPulse[i]),
         .clrPulse(eventClear[i]),
         .flag(eventFlags[i])
      );
      fcd_flag_bit u_irqs (
         .mclk(mclk),
         .reset(reset),
         .setPulse(eventPulse[i]),
         .clrPulse(statusRead),
         .flag(irqStatus[i])
      );
   end

   // port status flags: port C change and serial rx/tx done
   fcd_flag_bit u_port_c_change_status (
      .mclk(mclk),
      .reset(reset),
      .setPulse(portCChange),
      .clrPulse(op == FCD_OP_CPS0),
      .flag(portCChangeStatus)
   );
   fcd_flag_bit u_psr2rx (
      .mclk(mclk),
      .reset(reset),
      .setPulse(serialRxDone),
      .clrPulse(op == FCD_OP_CPS2),
      .flag(serialStatusFlags[0])
   );
   fcd_flag_bit u_psr2tx (
      .mclk(mclk),
      .reset(reset),
      .setPulse(serialTxDone),
      .clrPulse(op == FCD_OP_CPS2),
      .flag(serialStatusFlags[1])
   );

   // mask and memory window address, written by software
   always_ff @(posedge mclk) begin
      if (reset) begin
         irqMask <= 8'h00;
         memAddrReg <= 7'h00;
      end else if (regWrite) begin
         if (regAddr == `FCD_OFF_IRQ_MASK) begin
            irqMask <= regWrData[7:0] & `FCD_EVT_USED;
         end
         if (regAddr == `FCD_OFF_MEM_ADDR) begin
            memAddrReg <= regWrData[6:0];
         end
      end
   end

   // interrupt line lags status by a cycle, gated by the enable
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= intEnable && ((irqStatus & irqMask) != 8'h00);
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      next_rdData = 32'h00000000;
      case (regAddr)
         `FCD_OFF_IRQ_STAT: next_rdData[7:0] = irqStatus;
         `FCD_OFF_IRQ_MASK: next_rdData[7:0] = irqMask;
         `FCD_OFF_EVT: next_rdData[7:0] = eventFlags;
         `FCD_OFF_CORE: begin
            next_rdData[3:0] = accumulator;
            next_rdData[`FCD_CORE_CARRY] = carryFlag;
            next_rdData[`FCD_CORE_ZERO] = zeroFlag;
            next_rdData[`FCD_CORE_IE] = intEnable;
         end
         `FCD_OFF_PARM: next_rdData[3:0] = parameterFlags;
         `FCD_OFF_PSR: next_rdData[5:0] =
            {serialStatusFlags, 3'h0, portCChangeStatus};
         `FCD_OFF_DIV: next_rdData[13:0] = prescaleDivider;
         `FCD_OFF_WDT: next_rdData[17:0] = watchdog;
         `FCD_OFF_MEM_ADDR: next_rdData[6:0] = memAddrReg;
         `FCD_OFF_MEM_DATA: next_rdData[3:0] = memory[memAddrReg];
         default: next_rdData = 32'h00000000;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         regRdData <= 32'h00000000;
      end else if (regRead) begin
         regRdData <= next_rdData;
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_dec_exec;
      isDec;
   endsequence

   a_div_low_clear: assert property (
      op == FCD_OP_CDIV |=> prescaleDivider[3:0] == 4'h0 &&
         prescaleDivider[13:4] == $past(prescaleDivider[13:4]))
      else $error("divider low bits not cleared");

   for (genvar k = 0; k < 8; k++) begin : g_chk
      if (k != `FCD_EV_RSVD) begin : g_used
         a_evf_bit_clear: assert property (
            op == FCD_OP_CEVF && imm[k] && !eventPulse[k]
               |=> !eventFlags[k])
            else $error("event flag survived its clear");
      end
   end

   a_evf_keep_set: assert property (
      op == FCD_OP_CEVF && eventPulse != 8'h00
         |=> (eventFlags & $past(eventPulse)) == $past(eventPulse))
      else $error("event lost in its clearing cycle");

   a_wdt_slow_sel: assert property (
      op == FCD_OP_CPMF && imm[3] |=> !parameterFlags[`FCD_PARM_WDT]
         ##0 (wdtTick == (wdtPrescale == `FCD_WDT_SLOW_DIV)))
      else $error("watchdog clock not oscillator/1024");

   a_psr_clear: assert property (
      op == FCD_OP_CPS0 && !portCChange |=> !portCChangeStatus)
      else $error("port C change status not cleared");

   a_serial_clear: assert property (
      op == FCD_OP_CPS2 && !serialRxDone && !serialTxDone
         |=> serialStatusFlags == 2'h0)
      else $error("serial status flags not cleared");

   a_wdt_low_clear: assert property (
      op == FCD_OP_CWDT |=> watchdog[3:0] == 4'h0 &&
         watchdog[17:4] == $past(watchdog[17:4]))
      else $error("watchdog clear touched upper bits");

   a_dec_result: assert property (
      s_dec_exec |=> accumulator == $past(memOperand) - 4'h1 &&
         zeroFlag == (accumulator == 4'h0) &&
         carryFlag == ($past(memOperand) != 4'h0))
      else $error("decrement result or flags wrong");

   a_dec_address: assert property (
      s_dec_exec |=> memory[$past(opAddr)] == accumulator)
      else $error("decrement wrote the wrong location");

   a_irq_blocked: assert property (
      op == FCD_OP_DINT |=> !intEnable ##1 !irq)
      else $error("interrupt accepted after disable");

   a_skip_step: assert property (
      op == FCD_OP_SUB1SK |=>
         pcAdvance == (accumulator != 4'h0 ? 2'h2 : 2'h1))
      else $error("skip step wrong after decrement");
endmodule

// ---- dv/fcd_testbench.sv ----
// fcd_testbench: self-checking bench for the flag-clear/decrement executor
// assumes fcd_top alone; the bench drives every port, no far-side model
`timescale 1ns/1ns
`include "fcd_defines.svh"
`define CHK(got, exp) begin \
   checkCount++; \
   if ((got) !== (exp)) begin \
      nFail++; \
      $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
   end \
end

module testbench import fcd_pkg::*; ();
   // clock, reset and stimulus
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic instrValid = 1'b0;
   logic [15:0] instrWord = 16'h0000;
   logic [5:0] ev = 6'h00;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   // observed outputs
   logic [31:0] regRdData;
   logic instrDone;
   logic [1:0] pcAdvance;
   fcd_nib_t accumulator;
   logic carryFlag;
   logic zeroFlag;
   logic intEnable;
   logic wdtExpired;
   logic irq;
   // bench state
   int nFail = 0;
   int checkCount = 0;
   logic [31:0] d;
   logic [31:0] w1;
   logic [7:0] expEv;
   logic [13:0] dv;
   logic [6:0] addrs [3] = '{7'h7f, 7'h00, 7'h2a};
   fcd_nib_t vals [3] = '{4'h0, 4'h1, 4'h5};
   fcd_nib_t res;
   int evBits [6] = '{1, 2, 4, 5, 6, 7};

   fcd_top i_dut (
      .mclk(mclk), .reset(reset),
      .instrValid(instrValid), .instrWord(instrWord),
      .timer0Underflow(ev[0]), .portCChange(ev[1]), .extIrqFall(ev[2]),
      .serialRxDone(ev[3]), .serialTxDone(ev[4]), .timer1Underflow(ev[5]),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
      .regRead(regRead), .regRdData(regRdData),
      .instrDone(instrDone), .pcAdvance(pcAdvance),
      .accumulator(accumulator), .carryFlag(carryFlag),
      .zeroFlag(zeroFlag), .intEnable(intEnable),
      .wdtExpired(wdtExpired), .irq(irq)
   );

   // 4 ns clock
   initial begin
      forever #2 mclk = ~mclk;
   end

   // one-cycle register write
   task automatic regWr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask

   // read strobe, data taken in the following cycle only
   task automatic regRd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask

   // issue one instruction and check its completion pulse
   task automatic exec(input logic [15:0] w, input logic [1:0] pc);
      @(posedge mclk);
      instrValid <= 1'b1;
      instrWord <= w;
      @(posedge mclk);
      instrValid <= 1'b0;
      #1;
      `CHK(instrDone, 1'b1)
      `CHK(pcAdvance, pc)
   endtask

   // one-cycle pulse on the chosen event inputs
   task automatic pulse(input logic [5:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 6'h00;
   endtask

   task automatic giveVerdict();
      $display("checks %0d failures %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      #1;
      `CHK(pcAdvance, 2'h0)
      `CHK(intEnable, 1'b0)
      regRd(`FCD_OFF_PARM, d);
      `CHK(d, 32'h8)
      regRd(`FCD_OFF_CORE, d);
      `CHK(d, 32'h0)
      // divider overflow event, then its clear bit; bound avoids a hang
      for (int i = 0; i <= 9000; i++) begin
         regRd(`FCD_OFF_EVT, d);
         if (d[0] === 1'b1) break;
         if (i == 9000) begin
            nFail++;
            giveVerdict();
         end
      end
      exec({`FCD_PFX_CLR_EVT, 8'h01}, 2'h1);
      regRd(`FCD_OFF_EVT, d);
      `CHK(d[0], 1'b0)
      // all six external event sources; the reserved mask clears nothing, then one bit each
      pulse(6'h3f);
      expEv = `FCD_EVT_USED & 8'hfe;
      exec({`FCD_PFX_CLR_EVT, 8'h08}, 2'h1);
      regRd(`FCD_OFF_EVT, d);
      `CHK(d[7:1], expEv[7:1])
      foreach (evBits[k]) begin
         exec({`FCD_PFX_CLR_EVT, 8'h01 << evBits[k]},
            2'h1);
         expEv[evBits[k]] = 1'b0;
         regRd(`FCD_OFF_EVT, d);
         `CHK(d[7:1], expEv[7:1])
      end
      // port status: change flag alone, then both serial flags
      regRd(`FCD_OFF_PSR, d);
      `CHK(d, 32'h31)
      exec(`FCD_OP_CLR_PCHG, 2'h1);
      regRd(`FCD_OFF_PSR, d);
      `CHK(d, 32'h30)
      exec(`FCD_OP_CLR_SER, 2'h1);
      regRd(`FCD_OFF_PSR, d);
      `CHK(d, 32'h0)
      // divider: read, clear next cycle, read; two edges apart each way
      regRd(`FCD_OFF_DIV, d);
      dv = d[13:0] + 14'h2;
      exec(`FCD_OP_CLR_DIV, 2'h1);
      regRd(`FCD_OFF_DIV, d);
      `CHK(d[13:0], {dv[13:4], 4'h1})
      // watchdog: two clears close together leave upper bits alone
      exec(`FCD_OP_CLR_WDT, 2'h1);
      regRd(`FCD_OFF_WDT, w1);
      exec(`FCD_OP_CLR_WDT, 2'h1);
      regRd(`FCD_OFF_WDT, d);
      `CHK(d[17:4], w1[17:4])
      `CHK(d[3:0] <= 4'h1, 1'b1)
      // parameter flags: reserved bits do nothing, bit 3 picks /1024
      exec({`FCD_PFX_CLR_PARM, 4'h7}, 2'h1);
      regRd(`FCD_OFF_PARM, d);
      `CHK(d, 32'h8)
      exec({`FCD_PFX_CLR_PARM, 4'h8}, 2'h1);
      regRd(`FCD_OFF_PARM, d);
      `CHK(d, 32'h0)
      regWr(`FCD_OFF_PARM, 32'h8);
      // decrements: wrap, zero result, plain, on both opcodes
      regWr(`FCD_OFF_MEM_ADDR, 32'h55);
      regWr(`FCD_OFF_MEM_DATA, 32'h9);
      for (int op = 0; op < 2; op++) begin
         foreach (addrs[k]) begin
            res = vals[k] - 4'h1;
            regWr(`FCD_OFF_MEM_ADDR, {25'h0, addrs[k]});
            regWr(`FCD_OFF_MEM_DATA, {28'h0, vals[k]});
            if (op == 0) begin
               exec({`FCD_PFX_SUB1, addrs[k]}, 2'h1);
            end else begin
               exec({`FCD_PFX_SUB1SK, addrs[k]},
                  (res != 0) ? 2'h2 : 2'h1);
            end
            `CHK(accumulator, res)
            `CHK(carryFlag, vals[k] != 4'h0)
            `CHK(zeroFlag, res == 4'h0)
            regRd(`FCD_OFF_MEM_DATA, d);
            `CHK(d, {28'h0, res})
         end
      end
      regRd(`FCD_OFF_CORE, d);
      `CHK(d[5:0], 6'h14)
      regWr(`FCD_OFF_MEM_ADDR, 32'h55);
      regRd(`FCD_OFF_MEM_DATA, d);
      `CHK(d, 32'h9)
      // two decrements back to back on one nibble
      regWr(`FCD_OFF_MEM_DATA, 32'h3);
      @(posedge mclk);
      instrValid <= 1'b1;
      instrWord <= {`FCD_PFX_SUB1, 7'h55};
      @(posedge mclk);
      @(posedge mclk);
      instrValid <= 1'b0;
      #1;
      `CHK(accumulator, 4'h1)
      regRd(`FCD_OFF_MEM_DATA, d);
      `CHK(d, 32'h1)
      // unmapped address reads zero and ignores writes
      regWr(8'h30, 32'hffff);
      regRd(8'h30, d);
      `CHK(d, 32'h0)
      // interrupt gating: pending event waits for enable
      regRd(`FCD_OFF_IRQ_STAT, d);
      regWr(`FCD_OFF_IRQ_MASK, 32'hff);
      pulse(6'h04);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
      exec(`FCD_OP_EN_INT, 2'h1);
      `CHK(intEnable, 1'b1)
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b1)
      exec(`FCD_OP_IRQ_DISABLE_INSTR, 2'h1);
      `CHK(intEnable, 1'b0)
      repeat (2) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
      pulse(6'h20);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
      // read clears status; masked sources stay quiet
      regRd(`FCD_OFF_IRQ_STAT, d);
      regWr(`FCD_OFF_IRQ_MASK, 32'h0);
      exec(`FCD_OP_EN_INT, 2'h1);
      pulse(6'h04);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(irq, 1'b0)
      regRd(`FCD_OFF_IRQ_STAT, d);
      `CHK(d[4], 1'b1)
      regRd(`FCD_OFF_IRQ_STAT, d);
      `CHK(d[4], 1'b0)
      // watchdog runs on the fast tick but is far from wrapping here
      `CHK(wdtExpired, 1'b0)
      giveVerdict();
   end
endmodule
